// [verilog/ppsf_defs.svh]
`ifndef PPSF_DEFS_SVH
`define PPSF_DEFS_SVH

// Register offsets
`define PPSF_OFF_COMMON 4'h1
`define PPSF_OFF_PORT_CTRL1 4'h2
`define PPSF_OFF_PORT_CTRL2 4'h3
`define PPSF_OFF_STATUS1 4'h4
`define PPSF_OFF_CLASS_LO 4'h5
`define PPSF_OFF_CLASS_HI 4'h6

// Common control bits
`define PPSF_CC_ALL_DIS 0
`define PPSF_CC_SW_RST 1
`define PPSF_CC_UVOV_DIS 2

// Port control 1 fields
`define PPSF_PC1_FN_LSB 0
`define PPSF_PC1_FN_MSB 3
`define PPSF_PC1_UC_DIS 4
`define PPSF_PC1_DISC_FLT_DIS 5

// Reset values
`define PPSF_CC_RST 8'h00
`define PPSF_PC1_RST 8'h00
`define PPSF_PC2_RST 8'h0f

// Host-managed function codes
`define PPSF_FN_DISABLE 4'h0
`define PPSF_FN_C_SAMPLE 4'h7
`define PPSF_FN_RUP_PWR 4'h8
`define PPSF_FN_RDWN 4'h9

// Fault codes latched in the status register
`define PPSF_FC_NONE 3'h0
`define PPSF_FC_UVOV 3'h1
`define PPSF_FC_OC 3'h2
`define PPSF_FC_UC 3'h3
`define PPSF_FC_TSD 3'h4

// Timing, in the unit named
`define PPSF_CLK_KHZ 25000
`define PPSF_ADC_MS 18
`define PPSF_RAMP_UP_US 500
`define PPSF_RAMP_DOWN_US 300
`define PPSF_VOLT_MS 2
`define PPSF_OC_MS 50
`define PPSF_UC_MS 300
`define PPSF_RETRY_MS 750
`define PPSF_I2C_WD_MS 2000
`define PPSF_OSC_WD_MS 20
`define PPSF_LAST_SAMPLE 5'd31

`endif

// [verilog/ppsf_pkg.sv]
package ppsf_pkg;

	typedef enum logic [3:0] {
		PS_OFF,
		PS_DISC1,
		PS_DISC2,
		PS_CLASS_WAIT,
		PS_CLASS,
		PS_RAMP_UP,
		PS_POWERED,
		PS_RAMP_DOWN,
		PS_RETRY
	} ppsf_state_type;

	typedef logic [25:0] ppsf_timer_type;

endpackage

// [verilog/ppsf_top.sv]
`timescale 1ns/100ps
`include "ppsf_defs.svh"

module ppsf_top #(
	parameter int unsigned ADC_CYC = `PPSF_ADC_MS * `PPSF_CLK_KHZ,
	parameter int unsigned RAMP_UP_CYC = `PPSF_RAMP_UP_US * `PPSF_CLK_KHZ / 1000,
	parameter int unsigned RAMP_DOWN_CYC = `PPSF_RAMP_DOWN_US * `PPSF_CLK_KHZ / 1000,
	parameter int unsigned VOLT_CYC = `PPSF_VOLT_MS * `PPSF_CLK_KHZ,
	parameter int unsigned OC_CYC = `PPSF_OC_MS * `PPSF_CLK_KHZ,
	parameter int unsigned UC_CYC = `PPSF_UC_MS * `PPSF_CLK_KHZ,
	parameter int unsigned RETRY_CYC = `PPSF_RETRY_MS * `PPSF_CLK_KHZ,
	parameter int unsigned I2C_WD_CYC = `PPSF_I2C_WD_MS * `PPSF_CLK_KHZ,
	parameter int unsigned OSC_WD_CYC = `PPSF_OSC_WD_MS * `PPSF_CLK_KHZ
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic external_reset_pin_n,
	input wire logic operating_mode_select,
	input wire logic watchdog_defeat_pin,
	input wire logic i2c_scl,
	input wire logic osc_alive,
	input wire logic [3:0] reg_addr,
	input wire logic [1:0] reg_port,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic [3:0] signature_valid,
	input wire logic [11:0] class_meas,
	input wire logic [3:0] overcurrent_comparator,
	input wire logic [3:0] current_limit_comparator,
	input wire logic [3:0] undercurrent_det,
	input wire logic [3:0] voltage_out_of_window,
	input wire logic thermal_shutdown,
	output logic [3:0] port_switch_on,
	output logic [3:0] port_ramping,
	output logic [3:0] disc_probe_on,
	output logic [3:0] disc_probe_high,
	output logic [3:0] class_probe_on,
	output logic [3:0] meas_start,
	output logic [3:0] meas_voltage,
	output logic fault_irq_n_out,
	output logic fault_irq_n_oe_n
);
	import ppsf_pkg::*;

	localparam int SW = 38;
	localparam logic [SW-1:0] SYNC_RST = {1'b1, 37'h0};
	localparam ppsf_timer_type ADC_END = 26'(ADC_CYC - 1);
	localparam ppsf_timer_type RUP_END = 26'(RAMP_UP_CYC - 1);
	localparam ppsf_timer_type RDN_END = 26'(RAMP_DOWN_CYC - 1);
	localparam ppsf_timer_type VOLT_END = 26'(VOLT_CYC - 1);
	localparam ppsf_timer_type OC_END = 26'(OC_CYC - 1);
	localparam ppsf_timer_type UC_END = 26'(UC_CYC - 1);
	localparam ppsf_timer_type RETRY_END = 26'(RETRY_CYC - 1);
	localparam ppsf_timer_type I2C_END = 26'(I2C_WD_CYC - 1);
	localparam ppsf_timer_type OSC_END = 26'(OSC_WD_CYC - 1);

	// Counts while the condition holds, drops to zero the moment it clears
	function automatic ppsf_timer_type run_timer(input ppsf_timer_type cnt, input logic cond);
		run_timer = cond ? cnt + 26'd1 : 26'd0;
	endfunction

	logic [SW-1:0] sync1_q;
	logic [SW-1:0] sync2_q;
	logic scl_prev_q;
	logic osc_prev_q;
	logic external_reset_pin_s, host_managed_mode, watchdog_defeat_pin_s, scl_s, osc_s, tsd_s;
	logic [3:0] sig_s, ocmp_s, lim_s, uc_s, vbad_s;
	logic [11:0] class_s;
	logic soft_rst;
	logic wr_common, wr_pc1, wr_pc2;
	logic fn_go;
	logic [3:0] fn_code;
	logic [7:0] cc_q;
	logic [7:0] pc1_q [4];
	logic [7:0] pc2_q;
	logic [2:0] class_q [4];
	logic [2:0] fault_q [4];
	ppsf_state_type st_q [4];
	ppsf_timer_type tmr_q [4];
	ppsf_timer_type vt_q [4];
	ppsf_timer_type oct_q [4];
	ppsf_timer_type uct_q [4];
	logic [4:0] smp_q [4];
	logic [3:0] csamp_q;
	logic [3:0] meas_q;
	logic [3:0] meas_v_q;
	ppsf_timer_type i2c_tmr_q;
	ppsf_timer_type osc_tmr_q;
	logic i2c_wd_q;
	logic osc_lost_q;
	logic wd_kill;
	logic [3:0] grant;
	logic [2:0] fcode [4];
	logic any_fault;

	// Class value is held steady by the probe for the whole conversion,
	// so the bus skew through the synchroniser settles long before use
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sync1_q <= SYNC_RST;
			sync2_q <= SYNC_RST;
			scl_prev_q <= 1'b0;
			osc_prev_q <= 1'b0;
		end
		else
		begin
			sync1_q <= {external_reset_pin_n, operating_mode_select, watchdog_defeat_pin,
				i2c_scl, osc_alive, thermal_shutdown, signature_valid, overcurrent_comparator,
				current_limit_comparator, undercurrent_det, voltage_out_of_window, class_meas};
			sync2_q <= sync1_q;
			scl_prev_q <= scl_s;
			osc_prev_q <= osc_s;
		end
	end

	assign {external_reset_pin_s, host_managed_mode, watchdog_defeat_pin_s, scl_s, osc_s, tsd_s, sig_s, ocmp_s, lim_s, uc_s, vbad_s,
		class_s} = sync2_q;

	assign wr_common = reg_wr && (reg_addr == `PPSF_OFF_COMMON);
	assign wr_pc1 = reg_wr && (reg_addr == `PPSF_OFF_PORT_CTRL1);
	assign wr_pc2 = reg_wr && (reg_addr == `PPSF_OFF_PORT_CTRL2);
	assign soft_rst = !external_reset_pin_s || (wr_common && reg_wdata[`PPSF_CC_SW_RST]);
	assign fn_go = wr_pc1 && host_managed_mode;
	assign fn_code = reg_wdata[`PPSF_PC1_FN_MSB:`PPSF_PC1_FN_LSB];

	// Control registers
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cc_q <= `PPSF_CC_RST;
			pc2_q <= `PPSF_PC2_RST;
			for (int p = 0; p < 4; p++)
				pc1_q[p] <= `PPSF_PC1_RST;
		end
		else if (soft_rst)
		begin
			cc_q <= `PPSF_CC_RST;
			pc2_q <= `PPSF_PC2_RST;
			for (int p = 0; p < 4; p++)
				pc1_q[p] <= `PPSF_PC1_RST;
		end
		else
		begin
			if (wr_common)
				cc_q <= reg_wdata & ~(8'h01 << `PPSF_CC_SW_RST);
			if (wr_pc2)
				pc2_q <= reg_wdata;
			if (wr_pc1 && host_managed_mode)
				pc1_q[reg_port] <= reg_wdata;
			else if (wr_pc1)
				pc1_q[reg_port] <= {reg_wdata[7:4], pc1_q[reg_port][3:0]};
		end
	end

	// Watchdogs; defeat pin stops both
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			i2c_tmr_q <= 26'd0;
			i2c_wd_q <= 1'b0;
		end
		else if (soft_rst)
		begin
			i2c_tmr_q <= 26'd0;
			// An expiry landing on the reset cycle still latches
			i2c_wd_q <= host_managed_mode && !watchdog_defeat_pin_s && i2c_tmr_q == I2C_END;
		end
		else
		begin
			i2c_tmr_q <= run_timer(i2c_tmr_q, host_managed_mode && !watchdog_defeat_pin_s && (scl_s == scl_prev_q)
				&& (i2c_tmr_q != I2C_END));
			if (host_managed_mode && !watchdog_defeat_pin_s && i2c_tmr_q == I2C_END)
				i2c_wd_q <= 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			osc_tmr_q <= 26'd0;
			osc_lost_q <= 1'b0;
		end
		else
		begin
			osc_tmr_q <= run_timer(osc_tmr_q, !watchdog_defeat_pin_s && (osc_s == osc_prev_q)
				&& (osc_tmr_q != OSC_END));
			osc_lost_q <= !watchdog_defeat_pin_s && (osc_s == osc_prev_q) && (osc_lost_q
				|| osc_tmr_q == OSC_END);
		end
	end

	// A lost oscillator releases the ports once it runs again; an I2C fault does not
	assign wd_kill = i2c_wd_q || osc_lost_q;

	// Fault timers; each restarts the moment its condition clears
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			for (int p = 0; p < 4; p++)
			begin
				vt_q[p] <= 26'd0;
				oct_q[p] <= 26'd0;
				uct_q[p] <= 26'd0;
			end
		end
		else
		begin
			for (int p = 0; p < 4; p++)
			begin
				vt_q[p] <= run_timer(vt_q[p], st_q[p] == PS_POWERED && vbad_s[p]
					&& !cc_q[`PPSF_CC_UVOV_DIS] && !soft_rst);
				oct_q[p] <= run_timer(oct_q[p], (st_q[p] == PS_POWERED || st_q[p] == PS_RAMP_UP)
					&& (ocmp_s[p] || lim_s[p]) && !soft_rst);
				uct_q[p] <= run_timer(uct_q[p], st_q[p] == PS_POWERED && csamp_q[p] && uc_s[p]
					&& !pc1_q[p][`PPSF_PC1_UC_DIS] && !soft_rst);
			end
		end
	end

	// New fault code per port, thermal first
	always_comb
	begin
		for (int p = 0; p < 4; p++)
		begin
			fcode[p] = `PPSF_FC_NONE;
			if (tsd_s && st_q[p] != PS_OFF && st_q[p] != PS_RETRY)
				fcode[p] = `PPSF_FC_TSD;
			else if (oct_q[p] == OC_END)
				fcode[p] = `PPSF_FC_OC;
			else if (vt_q[p] == VOLT_END)
				fcode[p] = `PPSF_FC_UVOV;
			else if (uct_q[p] == UC_END)
				fcode[p] = `PPSF_FC_UC;
		end
	end

	// Lowest waiting port wins the single classification slot
	always_comb
	begin
		logic taken;
		taken = 1'b0;
		for (int p = 0; p < 4; p++)
			taken = taken || (st_q[p] == PS_CLASS);
		for (int p = 0; p < 4; p++)
		begin
			grant[p] = !taken && (st_q[p] == PS_CLASS_WAIT);
			taken = taken || grant[p];
		end
	end

	// Port sequencers
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			for (int p = 0; p < 4; p++)
			begin
				st_q[p] <= PS_OFF;
				tmr_q[p] <= 26'd0;
				smp_q[p] <= 5'd0;
				fault_q[p] <= `PPSF_FC_NONE;
				class_q[p] <= 3'h0;
			end
			csamp_q <= 4'h0;
			meas_q <= 4'h0;
			meas_v_q <= 4'h0;
		end
		else
		begin
			for (int p = 0; p < 4; p++)
			begin
				meas_q[p] <= 1'b0;
				tmr_q[p] <= tmr_q[p] + 26'd1;
				if (soft_rst)
				begin
					st_q[p] <= PS_OFF;
					fault_q[p] <= `PPSF_FC_NONE;
					class_q[p] <= 3'h0;
					csamp_q[p] <= 1'b0;
				end
				else if (fcode[p] != `PPSF_FC_NONE)
				begin
					st_q[p] <= PS_RETRY;
					fault_q[p] <= fcode[p];
					csamp_q[p] <= 1'b0;
					tmr_q[p] <= 26'd0;
				end
				else if (fn_go && reg_port == 2'(p) && fn_code == `PPSF_FN_DISABLE)
				begin
					st_q[p] <= PS_OFF;
					fault_q[p] <= `PPSF_FC_NONE;
					csamp_q[p] <= 1'b0;
				end
				else if (st_q[p] != PS_RETRY && (wd_kill || !pc2_q[p] || cc_q[`PPSF_CC_ALL_DIS]
					|| (host_managed_mode && st_q[p] >= PS_DISC1 && st_q[p] <= PS_CLASS)))
				begin
					st_q[p] <= PS_OFF;
					csamp_q[p] <= 1'b0;
				end
				else
				begin
					case (st_q[p])
						PS_OFF:
						begin
							tmr_q[p] <= 26'd0;
							if (!host_managed_mode)
								st_q[p] <= PS_DISC1;
							else if (fn_go && reg_port == 2'(p) && fn_code == `PPSF_FN_RUP_PWR)
								st_q[p] <= PS_RAMP_UP;
						end
						PS_DISC1:
							if (tmr_q[p] == ADC_END)
							begin
								st_q[p] <= PS_DISC2;
								tmr_q[p] <= 26'd0;
							end
						PS_DISC2:
							if (tmr_q[p] == ADC_END)
							begin
								st_q[p] <= sig_s[p] ? PS_CLASS_WAIT : PS_DISC1;
								tmr_q[p] <= 26'd0;
							end
						PS_CLASS_WAIT:
						begin
							tmr_q[p] <= 26'd0;
							if (grant[p])
								st_q[p] <= PS_CLASS;
						end
						PS_CLASS:
							if (tmr_q[p] == ADC_END)
							begin
								class_q[p] <= class_s[3*p +: 3];
								st_q[p] <= PS_RAMP_UP;
								tmr_q[p] <= 26'd0;
							end
						PS_RAMP_UP:
							if (tmr_q[p] == RUP_END)
							begin
								st_q[p] <= PS_POWERED;
								tmr_q[p] <= 26'd0;
								smp_q[p] <= 5'd0;
								csamp_q[p] <= !host_managed_mode;
							end
						PS_POWERED:
						begin
							if (fn_go && reg_port == 2'(p) && fn_code == `PPSF_FN_C_SAMPLE)
							begin
								// A repeat call leaves a running sequence alone, so no slot is cut short
								csamp_q[p] <= 1'b1;
								if (!csamp_q[p])
								begin
									smp_q[p] <= 5'd0;
									tmr_q[p] <= 26'd0;
								end
							end
							else if (fn_go && reg_port == 2'(p) && fn_code == `PPSF_FN_RDWN)
							begin
								st_q[p] <= PS_RAMP_DOWN;
								csamp_q[p] <= 1'b0;
								tmr_q[p] <= 26'd0;
							end
							else if (tmr_q[p] == ADC_END)
								tmr_q[p] <= 26'd0;
							else if (tmr_q[p] == 26'd0)
							begin
								// A new conversion starts at each slot boundary while current sampling is on
								meas_q[p] <= csamp_q[p];
								meas_v_q[p] <= (smp_q[p] == `PPSF_LAST_SAMPLE);
								if (csamp_q[p])
									smp_q[p] <= smp_q[p] + 5'd1;
							end
						end
						PS_RAMP_DOWN:
							if (tmr_q[p] == RDN_END)
								st_q[p] <= PS_OFF;
						PS_RETRY:
							if (!host_managed_mode && tmr_q[p] == RETRY_END)
							begin
								fault_q[p] <= `PPSF_FC_NONE;
								st_q[p] <= PS_OFF;
							end
							else if (host_managed_mode)
								tmr_q[p] <= 26'd0;
						default:
							st_q[p] <= PS_OFF;
					endcase
				end
			end
		end
	end

	// Port drive decoded straight from state registers
	always_comb
	begin
		for (int p = 0; p < 4; p++)
		begin
			port_switch_on[p] = (st_q[p] == PS_POWERED);
			port_ramping[p] = (st_q[p] == PS_RAMP_UP) || (st_q[p] == PS_RAMP_DOWN);
			disc_probe_on[p] = (st_q[p] == PS_DISC1) || (st_q[p] == PS_DISC2);
			disc_probe_high[p] = (st_q[p] == PS_DISC2);
			class_probe_on[p] = (st_q[p] == PS_CLASS);
		end
	end

	assign meas_start = meas_q;
	assign meas_voltage = meas_v_q;

	// Open drain: only ever pulls low
	assign any_fault = (fault_q[0] != 3'h0) || (fault_q[1] != 3'h0) || (fault_q[2] != 3'h0)
		|| (fault_q[3] != 3'h0);
	assign fault_irq_n_out = 1'b0;
	assign fault_irq_n_oe_n = !(any_fault || (host_managed_mode && wd_kill));

	// Read data
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			reg_rdata <= 8'h00;
		else
		begin
			case (reg_addr)
				`PPSF_OFF_COMMON:
					reg_rdata <= cc_q;
				`PPSF_OFF_PORT_CTRL1:
					reg_rdata <= pc1_q[reg_port];
				`PPSF_OFF_PORT_CTRL2:
					reg_rdata <= pc2_q;
				`PPSF_OFF_STATUS1:
					reg_rdata <= {3'h0, csamp_q[reg_port], port_switch_on[reg_port],
						fault_q[reg_port]};
				`PPSF_OFF_CLASS_LO:
					reg_rdata <= {2'h0, class_q[1], class_q[0]};
				`PPSF_OFF_CLASS_HI:
					reg_rdata <= {2'h0, class_q[3], class_q[2]};
				default:
					reg_rdata <= 8'h00;
			endcase
		end
	end

endmodule

// [testbench/ppsf_top_assertions.sv]
`timescale 1ns/100ps
module ppsf_checker #(
	parameter int unsigned OC_CYC = 20,
	parameter int unsigned OSC_WD_CYC = 20
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic watchdog_defeat_pin,
	input wire logic osc_alive,
	input wire logic [3:0] overcurrent_comparator,
	input wire logic [3:0] port_switch_on,
	input wire logic [3:0] port_ramping,
	input wire logic [3:0] disc_probe_on,
	input wire logic [3:0] disc_probe_high,
	input wire logic [3:0] class_probe_on,
	input wire logic [3:0] meas_start,
	input wire logic [3:0] meas_voltage,
	input wire logic fault_irq_n_oe_n
);
	logic osc_prev_q;
	logic [15:0] osc_idle_q;
	logic [15:0] oc_cnt_q;
	logic [4:0] vcnt_q;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	// Margin of five covers the input synchronisers and the state update
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			osc_prev_q <= 1'b0;
			osc_idle_q <= 16'h0;
		end
		else
		begin
			osc_prev_q <= osc_alive;
			if (osc_alive != osc_prev_q || watchdog_defeat_pin)
				osc_idle_q <= 16'h0;
			else if (osc_idle_q != 16'hffff)
				osc_idle_q <= osc_idle_q + 16'h1;
		end
	end
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			oc_cnt_q <= 16'h0;
		else if (overcurrent_comparator[0] && port_switch_on[0])
			oc_cnt_q <= oc_cnt_q + 16'h1;
		else
			oc_cnt_q <= 16'h0;
	end
	// Samples since power-on on port 0; every 32nd must be the voltage one
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			vcnt_q <= 5'h0;
		else if (!port_switch_on[0])
			vcnt_q <= 5'h0;
		else if (meas_start[0])
			vcnt_q <= vcnt_q + 5'h1;
	end
	property p_rst_off;
		$rose(rst_n) |-> port_switch_on == 4'h0 && fault_irq_n_oe_n;
	endproperty
	a_rst_off: assert property (p_rst_off) else $error("port on after reset");
	property p_one_class;
		$onehot0(class_probe_on);
	endproperty
	a_one_class: assert property (p_one_class) else $error("two ports classify");
	property p_probe;
		$rose(disc_probe_high[0]) |-> disc_probe_on[0] && $past(disc_probe_on[0]);
	endproperty
	a_probe: assert property (p_probe) else $error("high probe without low");
	property p_ramp;
		$rose(port_switch_on[1]) |-> $past(port_ramping[1]);
	endproperty
	a_ramp: assert property (p_ramp) else $error("switch on without ramp");
	property p_meas_on;
		(meas_start & ~port_switch_on) == 4'h0;
	endproperty
	a_meas_on: assert property (p_meas_on) else $error("sample on dead port");
	property p_meas_space;
		meas_start[1] |=> (!meas_start[1]) [*3];
	endproperty
	a_meas_space: assert property (p_meas_space) else $error("samples too close");
	property p_volt;
		meas_start[0] |-> meas_voltage[0] == (vcnt_q == 5'd31);
	endproperty
	a_volt: assert property (p_volt) else $error("voltage sample out of turn");
	property p_class_pow;
		(class_probe_on & port_switch_on) == 4'h0;
	endproperty
	a_class_pow: assert property (p_class_pow) else $error("class while powered");
	property p_osc_wd;
		osc_idle_q > OSC_WD_CYC + 5 |-> port_switch_on == 4'h0;
	endproperty
	a_osc_wd: assert property (p_osc_wd) else $error("port on without oscillator");
	property p_oc_lim;
		oc_cnt_q <= OC_CYC + 5;
	endproperty
	a_oc_lim: assert property (p_oc_lim) else $error("overcurrent not cut");
	c_off: cover property ($fell(port_switch_on[0]));
	c_class3: cover property ($rose(class_probe_on[3]));
	c_irq: cover property ($fell(fault_irq_n_oe_n));
endmodule

// [testbench/ppsf_pd_model.sv]
`timescale 1ns/100ps
module ppsf_pd_model (
	input wire logic [3:0] port_switch_on,
	input wire logic [3:0] sig_ok,
	input wire logic [3:0] oc_c,
	input wire logic [3:0] lim_c,
	input wire logic [3:0] uc_c,
	input wire logic [3:0] vw_c,
	output logic [3:0] signature_valid,
	output logic [3:0] overcurrent_comparator,
	output logic [3:0] current_limit_comparator,
	output logic [3:0] undercurrent_det,
	output logic [3:0] voltage_out_of_window
);
	// An unpowered load draws nothing, so no comparator can trip off power
	assign signature_valid = sig_ok;
	assign overcurrent_comparator = oc_c & port_switch_on;
	assign current_limit_comparator = lim_c & port_switch_on;
	assign undercurrent_det = uc_c & port_switch_on;
	assign voltage_out_of_window = vw_c & port_switch_on;
endmodule

// [testbench/ppsf_tb_top.sv]
`timescale 1ns/100ps
module ppsf_tb_top;
	localparam int OC = 30;
	localparam int UC = 40;
	localparam int VW = 20;
	localparam int RT = 60;
	localparam int I2CW = 200;
	localparam int OSCW = 100;
	logic clk = 0, rst_n = 0, pin_n = 1, mode = 0, wdd = 0, scl = 0, osc = 0, thermal = 0;
	logic scl_run = 1, osc_run = 1, reg_wr = 0, rd_f = 0, rd_d = 0, irq_oe_n, irq_out;
	logic [3:0] reg_addr = 0, sig_ok = 4'h7, oc_c = 0, lim_c = 0, uc_c = 0, vw_c = 0;
	logic [3:0] sig_v, oc_o, lim_o, uc_o, vw_o, sw, ramp;
	logic [1:0] reg_port = 0;
	logic [7:0] reg_wdata = 0, reg_rdata;
	logic [11:0] cls = 0;
	logic [15:0] e;
	logic [15:0] exp_q[$];
	logic [2:0] sc = 0;
	int errors = 0, tests_run = 0, seed = 54, n;

	ppsf_top #(.ADC_CYC(8), .RAMP_UP_CYC(20), .RAMP_DOWN_CYC(20), .VOLT_CYC(VW), .OC_CYC(OC),
		.UC_CYC(UC), .RETRY_CYC(RT), .I2C_WD_CYC(I2CW), .OSC_WD_CYC(OSCW)) i_dut (
		.clk(clk), .rst_n(rst_n), .external_reset_pin_n(pin_n), .operating_mode_select(mode),
		.watchdog_defeat_pin(wdd), .i2c_scl(scl), .osc_alive(osc), .reg_addr(reg_addr),
		.reg_port(reg_port), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.signature_valid(sig_v), .class_meas(cls), .overcurrent_comparator(oc_o),
		.current_limit_comparator(lim_o), .undercurrent_det(uc_o), .voltage_out_of_window(vw_o),
		.thermal_shutdown(thermal), .port_switch_on(sw), .port_ramping(ramp),
		.disc_probe_on(), .disc_probe_high(), .class_probe_on(), .meas_start(),
		.meas_voltage(), .fault_irq_n_out(irq_out), .fault_irq_n_oe_n(irq_oe_n));
	ppsf_pd_model i_pd (.port_switch_on(sw), .sig_ok(sig_ok), .oc_c(oc_c), .lim_c(lim_c),
		.uc_c(uc_c), .vw_c(vw_c), .signature_valid(sig_v), .overcurrent_comparator(oc_o),
		.current_limit_comparator(lim_o), .undercurrent_det(uc_o), .voltage_out_of_window(vw_o));

	initial forever #20 clk = ~clk;
	always @(posedge clk)
	begin
		sc <= sc + 3'h1;
		if (scl_run && sc == 3'h0) scl <= ~scl;
		if (osc_run) osc <= ~osc;
		rd_d <= rd_f;
		if (rd_d)
		begin
			e = exp_q.pop_front();
			chk(reg_rdata & e[15:8], e[7:0]);
		end
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [1:0] p, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_port <= p;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [1:0] p, input logic [7:0] m,
		input logic [7:0] x);
		@(posedge clk);
		reg_addr <= a;
		reg_port <= p;
		rd_f <= 1'b1;
		exp_q.push_back({m, x});
		@(posedge clk);
		rd_f <= 1'b0;
	endtask
	task automatic wsw(input int p, input logic v, input int lim);
		n = 0;
		while (sw[p] !== v && n < lim)
		begin
			@(posedge clk);
			n++;
		end
		@(negedge clk);
		chk(sw[p], v);
		@(posedge clk);
	endtask
	task automatic stay(input int p, input logic v, input int c);
		repeat (c) @(posedge clk);
		@(negedge clk);
		chk(sw[p], v);
		@(posedge clk);
	endtask
	task automatic final_report;
		repeat (4) @(posedge clk);
		$display("Checks run %0d, mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial
	begin
		#(40 * 8000);
		errors++;
		final_report;
	end
	initial
	begin
		repeat (2) @(posedge clk);
		cls <= 12'($random(seed));
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		rd(1, 0, 8'hff, 8'h00);
		rd(3, 0, 8'hff, 8'h0f);
		rd(0, 0, 8'hff, 8'h00);
		wr(2, 0, 8'h18);
		rd(2, 0, 8'hff, 8'h10);
		wsw(2, 1, 400);
		stay(3, 0, 60);
		sig_ok <= 4'hf;
		wsw(3, 1, 400);
		rd(5, 0, 8'h07, {5'h0, cls[2:0]});
		rd(4, 0, 8'h0f, 8'h08);
		oc_c <= 4'h1;
		wsw(0, 0, OC + 20);
		chk(8'(n >= OC), 8'h01);
		oc_c <= 4'h0;
		rd(4, 0, 8'h07, 8'h02);
		chk(irq_oe_n, 1'b0);
		chk(irq_out, 1'b0);
		repeat (RT + 10) @(posedge clk);
		chk(irq_oe_n, 1'b1);
		rd(4, 0, 8'h07, 8'h00);
		mode <= 1'b1;
		pin_n <= 1'b0;
		repeat (4) @(posedge clk);
		pin_n <= 1'b1;
		stay(1, 0, 30);
		wr(2, 1, 8'h08);
		@(negedge clk);
		chk(ramp[1], 1'b1);
		wsw(1, 1, 60);
		uc_c <= 4'h2;
		stay(1, 1, UC + 10);
		wr(2, 1, 8'h17);
		stay(1, 1, UC + 10);
		wr(2, 1, 8'h07);
		wsw(1, 0, UC + 20);
		uc_c <= 4'h0;
		rd(4, 1, 8'h07, 8'h03);
		chk(irq_oe_n, 1'b0);
		wr(2, 1, 8'h08);
		stay(1, 0, 30);
		wr(2, 1, 8'h00);
		rd(4, 1, 8'h07, 8'h00);
		wr(2, 1, 8'h08);
		wsw(1, 1, 60);
		wr(1, 0, 8'h04);
		vw_c <= 4'h2;
		stay(1, 1, VW + 10);
		wr(1, 0, 8'h00);
		wsw(1, 0, VW + 10);
		rd(4, 1, 8'h07, 8'h01);
		vw_c <= 4'h0;
		wr(2, 1, 8'h00);
		wr(2, 1, 8'h08);
		wsw(1, 1, 60);
		// Two bursts, each shorter than the timeout, together longer
		repeat (2)
		begin
			oc_c <= 4'h2;
			repeat (OC - 10) @(posedge clk);
			oc_c <= 4'h0;
			repeat (4) @(posedge clk);
		end
		stay(1, 1, 4);
		lim_c <= 4'h2;
		wsw(1, 0, OC + 20);
		rd(4, 1, 8'h07, 8'h02);
		lim_c <= 4'h0;
		wr(2, 1, 8'h00);
		wr(2, 1, 8'h08);
		wsw(1, 1, 60);
		thermal <= 1'b1;
		wsw(1, 0, 10);
		rd(4, 1, 8'h07, 8'h04);
		thermal <= 1'b0;
		wr(2, 1, 8'h00);
		wr(2, 1, 8'h08);
		wsw(1, 1, 60);
		scl_run <= 1'b0;
		wsw(1, 0, I2CW + 40);
		chk(irq_oe_n, 1'b0);
		scl_run <= 1'b1;
		wr(2, 1, 8'h08);
		stay(1, 0, 30);
		wr(1, 0, 8'h02);
		wr(2, 1, 8'h08);
		wsw(1, 1, 60);
		mode <= 1'b0;
		wsw(0, 1, 400);
		osc_run <= 1'b0;
		wsw(0, 0, OSCW + 20);
		chk(irq_oe_n, 1'b1);
		osc_run <= 1'b1;
		final_report;
	end
endmodule

bind ppsf_top ppsf_checker #(.OC_CYC(OC_CYC), .OSC_WD_CYC(OSC_WD_CYC)) i_chk (.clk(clk),
	.rst_n(rst_n), .watchdog_defeat_pin(watchdog_defeat_pin), .osc_alive(osc_alive),
	.overcurrent_comparator(overcurrent_comparator), .port_switch_on(port_switch_on),
	.port_ramping(port_ramping), .disc_probe_on(disc_probe_on), .disc_probe_high(disc_probe_high),
	.class_probe_on(class_probe_on), .meas_start(meas_start), .meas_voltage(meas_voltage),
	.fault_irq_n_oe_n(fault_irq_n_oe_n));
